// ---- hdl/ebpc_pin_ctrl.v ----
// Purpose: Pin-state and pin-function control of the external bus and strap pins
// Assumes: rst_n is the power-on reset; all inputs synchronous to mclk
// Notes: Pin outputs are registered, so they follow the state one cycle later
// Behaviour
// - Strap levels are captured at power-on reset and used as configuration afterwards.
// - Clock pin directions follow the captured three-bit clock mode.
// - Serial enable turns the low three straps into serial clock, output, input.
// - Area 2 dynamic memory enable turns the endian strap into row strobe.
// - Area 6 card enable turns one width strap into second card enable.
// - Area 5 card enable turns the other width strap into card enable.
// - Chip-active low moves the device into hardware standby.
// - Keep state: port inputs float, port outputs other than the top two data bits hold their last level.
// - Top two data bits drive outside power-on reset when port in use.
// - In hardware standby the timer clock pin is input or driven low.
// - In standby selects, start and write strobes float or drive high.
// - Row strobe pin is input unless used; standby and release float or drive.
// - Sixteen-bit byte writes assert one lane strobe; wider writes assert both.
// - Even bytes on low lane, odd bytes on next on a 16-bit bus, all on low lane on an 8-bit bus; strobes high on reads.
// - Read pulse low on reads, high on writes; read/write high reads.
// - Wait request ignored when the area wait setting is zero.
// - Area 6 second card enable floats when area 6 card mode is off.
`include "ebpc_defines.vh"
module ebpc_pin_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire manual_rst,
  input wire sleep_req,
  input wire standby_req,
  input wire chip_active_in,
  input wire bus_grant_request_n,
  output wire bus_ack_n,
  output wire hw_standby,
  input wire serial_en,
  input wire area2_dram_en,
  input wire area5_card_en,
  input wire area6_card_mode_bit,
  input wire standby_hiz_sel,
  input wire ras2_hiz_sel,
  input wire timer_clk_out_sel,
  input wire port_en,
  input wire [7:0] port_dir,
  input wire [7:0] port_out,
  input wire [1:0] port_top2_out,
  input wire [2:0] wait_setting_reg,
  input wire strap0_serial_clock_i,
  output wire strap0_serial_clock_o,
  output wire strap0_serial_clock_oe,
  input wire strap1_serial_out_i,
  output wire strap1_serial_out_o,
  output wire strap1_serial_out_oe,
  input wire strap2_serial_in_i,
  input wire width_strap_card_enable_a_i,
  output wire width_strap_card_enable_a_o,
  output wire width_strap_card_enable_a_oe,
  input wire width_strap_card_enable_b_i,
  output wire width_strap_card_enable_b_o,
  output wire width_strap_card_enable_b_oe,
  input wire endian_strap_row_strobe2_i,
  output wire endian_strap_row_strobe2_o,
  output wire endian_strap_row_strobe2_oe,
  output wire [2:0] clock_mode_straps,
  output wire big_endian_mode,
  output wire [1:0] area0_width_mode,
  output wire ckio_oe,
  output wire xtal_osc_en,
  input wire sci_clk_out,
  input wire sci_clk_drive,
  input wire sci_tx_data,
  output wire sci_clk_in,
  output wire sci_rx_data,
  input wire dram_ras2_n,
  input wire timer_clk_src,
  input wire timer_clock_pin_i,
  output wire timer_clock_pin_o,
  output wire timer_clock_pin_oe,
  output wire timer_clk_in,
  input wire acc_valid,
  input wire acc_write,
  input wire [1:0] acc_size,
  input wire [25:0] acc_addr,
  input wire [2:0] acc_area,
  input wire acc_card,
  input wire acc_bus16,
  input wire [15:0] acc_wdata,
  input wire wait_req_n,
  input wire card_io_width_flag,
  output wire wait_active,
  output wire card_io16,
  output wire [25:0] addr_o,
  output wire addr_oe,
  output wire [6:0] area_selects_n,
  output wire area_selects_oe,
  output wire cycle_start_strobe_n,
  output wire cycle_start_strobe_oe,
  output wire rd_n,
  output wire rd_wr,
  output wire rd_oe,
  output wire lane0_write_strobe_n,
  output wire lane1_write_strobe_n,
  output wire write_strobe_oe,
  input wire [15:0] data_i,
  output wire [15:0] data_o,
  output wire [1:0] data_lane_oe,
  output wire [15:0] read_data,
  input wire [7:0] port_pin_i,
  output wire [7:0] port_pin_o,
  output wire [7:0] port_pin_oe,
  output wire [7:0] port_in,
  output wire [1:0] data_top2_o,
  output wire data_top2_oe
);
  localparam ST_POR = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_SLEEP = 3'd2;
  localparam ST_STBY = 3'd3;
  localparam ST_HWSTBY = 3'd4;
  localparam ST_REL = 3'd5;
  localparam ST_MRST = 3'd6;

  function area_hit;
    input [2:0] area;
    input [2:0] idx;
    begin
      area_hit = (area == idx);
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [5:0] strap_q;
  reg [25:0] addr_q;
  reg addr_oe_q;
  reg [6:0] cs_q;
  reg [6:0] cs_d;
  reg strobe_oe_q;
  reg bs_q;
  reg rd_q;
  reg rdwr_q;
  reg rd_oe_q;
  reg we0_q;
  reg we1_q;
  reg [15:0] data_q;
  reg [1:0] data_oe_q;
  reg wait_q;
  reg io16_q;
  reg back_q;
  reg ce2a_q;
  reg ce2a_oe_q;
  reg ce2b_q;
  reg ce2b_oe_q;
  reg ras2_q;
  reg ras2_oe_q;
  reg timer_clock_pin_q;
  reg timer_clock_pin_oe_q;
  reg [7:0] port_q;
  reg [7:0] port_oe_q;
  reg [1:0] top2_q;
  reg top2_oe_q;
  reg s0_q;
  reg s0_oe_q;
  reg s1_q;
  reg s1_oe_q;

  wire por = (state_q == ST_POR);
  wire run = (state_q == ST_RUN);
  wire rel = (state_q == ST_REL);
  wire hw = (state_q == ST_HWSTBY);
  wire stby = (state_q == ST_STBY) || hw;
  wire access = run && acc_valid;
  wire upper_lane = acc_bus16 && ((acc_size != `EBPC_SZ_BYTE) || acc_addr[0]);
  wire lane0_we_n;
  wire lane1_we_n;
  wire [1:0] lane_used;
  wire [15:0] lane_data;
  wire strobe_oe_d = stby ? !standby_hiz_sel : !rel;
  wire ras2_used = area2_dram_en && !por;
  wire ce2a_used = area5_card_en && !por;
  wire ce2b_used = area6_card_mode_bit && !por;
  wire [7:0] ckio_mask = `EBPC_CKIO_OUT_MASK;
  wire [7:0] xtal_mask = `EBPC_XTAL_USE_MASK;

  ebpc_lane_dec u_lane (
    .acc_write(acc_write),
    .acc_size(acc_size),
    .acc_addr0(acc_addr[0]),
    .bus16(acc_bus16),
    .acc_wdata(acc_wdata),
    .lane0_we_n(lane0_we_n),
    .lane1_we_n(lane1_we_n),
    .lane_used(lane_used),
    .lane_data(lane_data)
  );

  // Hardware standby is left only through power-on reset
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POR: state_d = ST_RUN;
      ST_HWSTBY: state_d = ST_HWSTBY;
      default: begin
        if (!chip_active_in) begin
          state_d = ST_HWSTBY;
        end else if (manual_rst) begin
          state_d = ST_MRST;
        end else if (standby_req) begin
          state_d = ST_STBY;
        end else if (state_q == ST_STBY) begin
          state_d = ST_RUN;
        end else if (!bus_grant_request_n && !(run && acc_valid)) begin
          state_d = ST_REL;
        end else if (sleep_req) begin
          state_d = ST_SLEEP;
        end else begin
          state_d = ST_RUN;
        end
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_cs
      always @* begin
        cs_d[gi] = !(access && area_hit(acc_area, gi));
      end
    end
  endgenerate

  // Straps are sampled in the first cycle after power-on reset releases
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_POR;
      strap_q <= `EBPC_STRAP_RST;
    end else begin
      state_q <= state_d;
      if (por) begin
        strap_q <= {endian_strap_row_strobe2_i, width_strap_card_enable_b_i,
                    width_strap_card_enable_a_i, strap2_serial_in_i,
                    strap1_serial_out_i, strap0_serial_clock_i};
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `EBPC_ADDR_RST;
      addr_oe_q <= 1'b1;
      cs_q <= `EBPC_CS_IDLE;
      strobe_oe_q <= 1'b1;
      bs_q <= 1'b1;
      rd_q <= 1'b1;
      rdwr_q <= 1'b1;
      rd_oe_q <= 1'b1;
      we0_q <= 1'b1;
      we1_q <= 1'b1;
      data_q <= `EBPC_DATA_RST;
      data_oe_q <= `EBPC_LANE_NONE;
      wait_q <= 1'b0;
      io16_q <= 1'b0;
      back_q <= 1'b1;
    end else begin
      addr_q <= acc_addr;
      addr_oe_q <= !(rel || stby);
      cs_q <= cs_d;
      strobe_oe_q <= strobe_oe_d;
      bs_q <= !access;
      rd_q <= !(access && !acc_write);
      rdwr_q <= !(access && acc_write);
      rd_oe_q <= !(rel || stby);
      we0_q <= !access || lane0_we_n;
      we1_q <= !access || lane1_we_n;
      data_q <= lane_data;
      data_oe_q <= (access && acc_write) ? lane_used : `EBPC_LANE_NONE;
      wait_q <= access && !wait_req_n && (wait_setting_reg != `EBPC_WAIT_NONE);
      io16_q <= access && acc_card && card_io_width_flag;
      back_q <= !rel;
    end
  end

  // Mode pins stay inputs until software hands them a second function
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce2a_q <= 1'b1;
      ce2a_oe_q <= 1'b0;
      ce2b_q <= 1'b1;
      ce2b_oe_q <= 1'b0;
      ras2_q <= 1'b1;
      ras2_oe_q <= 1'b0;
      s0_q <= 1'b0;
      s0_oe_q <= 1'b0;
      s1_q <= 1'b0;
      s1_oe_q <= 1'b0;
      timer_clock_pin_q <= 1'b0;
      timer_clock_pin_oe_q <= 1'b0;
    end else begin
      ce2a_q <= !(access && acc_card && area_hit(acc_area, `EBPC_AREA5) && upper_lane);
      ce2a_oe_q <= ce2a_used && !rel && !(stby && standby_hiz_sel);
      ce2b_q <= !(access && acc_card && area_hit(acc_area, `EBPC_AREA6) && upper_lane);
      ce2b_oe_q <= ce2b_used && !rel && !(stby && standby_hiz_sel);
      ras2_q <= dram_ras2_n;
      ras2_oe_q <= ras2_used && !((stby || rel) && ras2_hiz_sel);
      s0_q <= sci_clk_out;
      s0_oe_q <= serial_en && !por && sci_clk_drive;
      s1_q <= sci_tx_data;
      s1_oe_q <= serial_en && !por;
      timer_clock_pin_q <= hw ? 1'b0 : timer_clk_src;
      timer_clock_pin_oe_q <= !por && timer_clk_out_sel;
    end
  end

  // Port outputs refresh only while running, so every other state keeps them
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_port
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          port_q[gi] <= 1'b0;
          port_oe_q[gi] <= 1'b0;
        end else begin
          if (run) begin
            port_q[gi] <= port_out[gi];
          end
          port_oe_q[gi] <= !por && port_en && port_dir[gi];
        end
      end
    end
  endgenerate

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      top2_q <= `EBPC_TOP2_RST;
      top2_oe_q <= 1'b0;
    end else begin
      top2_q <= port_top2_out;
      top2_oe_q <= !por && port_en;
    end
  end

  assign bus_ack_n = back_q;
  assign hw_standby = hw;
  assign clock_mode_straps = strap_q[2:0];
  assign area0_width_mode = strap_q[4:3];
  assign big_endian_mode = strap_q[5];
  assign ckio_oe = ckio_mask[strap_q[2:0]];
  assign xtal_osc_en = xtal_mask[strap_q[2:0]];
  assign strap0_serial_clock_o = s0_q;
  assign strap0_serial_clock_oe = s0_oe_q;
  assign strap1_serial_out_o = s1_q;
  assign strap1_serial_out_oe = s1_oe_q;
  assign sci_clk_in = strap0_serial_clock_i;
  assign sci_rx_data = strap2_serial_in_i;
  assign width_strap_card_enable_a_o = ce2a_q;
  assign width_strap_card_enable_a_oe = ce2a_oe_q;
  assign width_strap_card_enable_b_o = ce2b_q;
  assign width_strap_card_enable_b_oe = ce2b_oe_q;
  assign endian_strap_row_strobe2_o = ras2_q;
  assign endian_strap_row_strobe2_oe = ras2_oe_q;
  assign timer_clock_pin_o = timer_clock_pin_q;
  assign timer_clock_pin_oe = timer_clock_pin_oe_q;
  assign timer_clk_in = timer_clock_pin_i;
  assign wait_active = wait_q;
  assign card_io16 = io16_q;
  assign addr_o = addr_q;
  assign addr_oe = addr_oe_q;
  assign area_selects_n = cs_q;
  assign area_selects_oe = strobe_oe_q;
  assign cycle_start_strobe_n = bs_q;
  assign cycle_start_strobe_oe = strobe_oe_q;
  assign rd_n = rd_q;
  assign rd_wr = rdwr_q;
  assign rd_oe = rd_oe_q;
  assign lane0_write_strobe_n = we0_q;
  assign lane1_write_strobe_n = we1_q;
  assign write_strobe_oe = strobe_oe_q;
  assign data_o = data_q;
  assign data_lane_oe = data_oe_q;
  assign read_data = data_i;
  assign port_pin_o = port_q;
  assign port_pin_oe = port_oe_q;
  assign port_in = port_pin_i;
  assign data_top2_o = top2_q;
  assign data_top2_oe = top2_oe_q;
endmodule

// ---- hdl/ebpc_defines.vh ----
// Purpose: Shared constants for the external bus pin-state controller
// Assumes: Included by every design file of the block
// Notes: Clock mode masks are indexed by the captured clock mode straps
`ifndef EBPC_DEFINES_VH
`define EBPC_DEFINES_VH

`define EBPC_STRAP_RST 6'h00
`define EBPC_CKIO_OUT_MASK 8'h0F
`define EBPC_XTAL_USE_MASK 8'h33
`define EBPC_AREA2 3'h2
`define EBPC_AREA5 3'h5
`define EBPC_AREA6 3'h6
`define EBPC_SZ_BYTE 2'h0
`define EBPC_WAIT_NONE 3'h0
`define EBPC_CS_IDLE 7'h7F
`define EBPC_ADDR_RST 26'h000_0000
`define EBPC_DATA_RST 16'h0000
`define EBPC_LANE_NONE 2'h0
`define EBPC_LANE_BOTH 2'h3
`define EBPC_LANE_LOW 2'h1
`define EBPC_LANE_HIGH 2'h2
`define EBPC_PORT_RST 8'h00
`define EBPC_TOP2_RST 2'h0

`endif

// ---- hdl/ebpc_lane_dec.v ----
// Purpose: Byte-lane strobe and data-lane steering for normal-memory cycles
// Assumes: Little-endian byte order; bus width 8 or 16 bits
// Notes: Purely combinational; the caller registers the results
`include "ebpc_defines.vh"
module ebpc_lane_dec (
  input wire acc_write,
  input wire [1:0] acc_size,
  input wire acc_addr0,
  input wire bus16,
  input wire [15:0] acc_wdata,
  output reg lane0_we_n,
  output reg lane1_we_n,
  output reg [1:0] lane_used,
  output reg [15:0] lane_data
);
  always @* begin
    lane_used = `EBPC_LANE_BOTH;
    lane_data = acc_wdata;
    if (!bus16) begin
      lane_used = `EBPC_LANE_LOW;
    end else if (acc_size == `EBPC_SZ_BYTE) begin
      if (acc_addr0) begin
        lane_used = `EBPC_LANE_HIGH;
        lane_data = {acc_wdata[7:0], acc_wdata[7:0]};
      end else begin
        lane_used = `EBPC_LANE_LOW;
      end
    end
    // Strobes stay high on reads whatever the lanes
    lane0_we_n = !(acc_write && lane_used[0]);
    lane1_we_n = !(acc_write && lane_used[1]);
  end
endmodule

// ---- dv/ebpc_pin_ctrl_props.sv ----
// Purpose: Port assertions for the pin-state controller
// Assumes: One clock; rst_n asynchronous, active low
// Notes: Access checks wait until the state has settled in run
module ebpc_pin_ctrl_props (
  input wire mclk,
  input wire rst_n,
  input wire manual_rst,
  input wire sleep_req,
  input wire standby_req,
  input wire chip_active_in,
  input wire bus_grant_request_n,
  input wire bus_ack_n,
  input wire hw_standby,
  input wire area6_card_mode_bit,
  input wire width_strap_card_enable_b_oe,
  input wire acc_valid,
  input wire acc_write,
  input wire [1:0] acc_size,
  input wire [25:0] acc_addr,
  input wire acc_bus16,
  input wire rd_n,
  input wire rd_wr,
  input wire rd_oe,
  input wire addr_oe,
  input wire lane0_write_strobe_n,
  input wire lane1_write_strobe_n,
  input wire [6:0] area_selects_n,
  input wire [1:0] data_lane_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] cnt_q;
  reg calm_q;
  wire calm = !manual_rst && !sleep_req && !standby_req && chip_active_in && !hw_standby;
  // State lags its cause by one edge, so the previous cycle must be calm too
  wire ok = cnt_q == 2'h3 && calm && calm_q && bus_grant_request_n;
  wire acc_w = ok && acc_valid && acc_write && acc_bus16;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      calm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {1'b0, cnt_q != 2'h3};
      calm_q <= calm && bus_grant_request_n;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_por;
    $rose(rst_n) |-> area_selects_n == 7'h7F && rd_n && lane0_write_strobe_n
      && lane1_write_strobe_n && data_lane_oe == 2'h0;
  endproperty
  a_por: assert property (p_por) else $error("reset pin levels wrong");
  property p_rd;
    ok && acc_valid && !acc_write |=> !rd_n && rd_wr && lane0_write_strobe_n
      && lane1_write_strobe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobes wrong");
  property p_wr;
    ok && acc_valid && acc_write |=> rd_n && !rd_wr;
  endproperty
  a_wr: assert property (p_wr) else $error("write direction wrong");
  property p_odd;
    acc_w && acc_size == 2'h0 && acc_addr[0] |=> lane0_write_strobe_n
      && !lane1_write_strobe_n && data_lane_oe == 2'h2;
  endproperty
  a_odd: assert property (p_odd) else $error("odd byte lane wrong");
  property p_even;
    acc_w && acc_size == 2'h0 && !acc_addr[0] |=> !lane0_write_strobe_n
      && lane1_write_strobe_n && data_lane_oe == 2'h1;
  endproperty
  a_even: assert property (p_even) else $error("even byte lane wrong");
  property p_word;
    acc_w && acc_size != 2'h0 |=> !lane0_write_strobe_n && !lane1_write_strobe_n
      && data_lane_oe == 2'h3;
  endproperty
  a_word: assert property (p_word) else $error("wide write lanes wrong");
  property p_hws;
    cnt_q == 2'h3 && !chip_active_in |=> hw_standby [*2];
  endproperty
  a_hws: assert property (p_hws) else $error("standby not entered");
  property p_rel;
    cnt_q == 2'h3 && !$past(standby_req) && calm && !bus_grant_request_n && !acc_valid ##1 calm
      && !bus_grant_request_n |=> !bus_ack_n && !addr_oe && !rd_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("release pins wrong");
  property p_ce2b;
    !area6_card_mode_bit |=> !width_strap_card_enable_b_oe;
  endproperty
  a_ce2b: assert property (p_ce2b) else $error("card enable driven");
endmodule
bind ebpc_pin_ctrl ebpc_pin_ctrl_props u_props (.*);

// ---- dv/ebpc_board.sv ----
// Purpose: Board straps, chip-active line and card width flag
// Assumes: Straps are resistors that a driving device overrides
// Notes: Chip-active can only drop outside power-on reset
module ebpc_board (
  input wire rst_n,
  input wire [5:0] strap_set,
  input wire ca_drop,
  input wire card16,
  input wire strap0_serial_clock_o,
  input wire strap0_serial_clock_oe,
  input wire strap1_serial_out_o,
  input wire strap1_serial_out_oe,
  input wire width_strap_card_enable_a_o,
  input wire width_strap_card_enable_a_oe,
  input wire width_strap_card_enable_b_o,
  input wire width_strap_card_enable_b_oe,
  input wire endian_strap_row_strobe2_o,
  input wire endian_strap_row_strobe2_oe,
  output wire strap0_serial_clock_i,
  output wire strap1_serial_out_i,
  output wire strap2_serial_in_i,
  output wire width_strap_card_enable_a_i,
  output wire width_strap_card_enable_b_i,
  output wire endian_strap_row_strobe2_i,
  output wire chip_active_in,
  output wire card_io_width_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  assign strap0_serial_clock_i = strap0_serial_clock_oe ? strap0_serial_clock_o : strap_set[0];
  assign strap1_serial_out_i = strap1_serial_out_oe ? strap1_serial_out_o : strap_set[1];
  assign strap2_serial_in_i = strap_set[2];
  assign width_strap_card_enable_a_i =
    width_strap_card_enable_a_oe ? width_strap_card_enable_a_o : strap_set[3];
  assign width_strap_card_enable_b_i =
    width_strap_card_enable_b_oe ? width_strap_card_enable_b_o : strap_set[4];
  assign endian_strap_row_strobe2_i =
    endian_strap_row_strobe2_oe ? endian_strap_row_strobe2_o : strap_set[5];
  assign chip_active_in = !rst_n || !ca_drop;
  assign card_io_width_flag = card16;
endmodule

// ---- dv/ebpc_pin_ctrl_test.sv ----
// Purpose: Self-checking bench for the pin-state controller
// Assumes: Outputs follow inputs one edge later
// Notes: Hardware standby is left only by reset, so it runs last
`include "ebpc_defines.vh"
module ebpc_pin_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, manual_rst = 0, sleep_req = 0, standby_req = 0, ca_drop = 0;
  logic bus_grant_request_n = 1, serial_en = 0, area2_dram_en = 0, area5_card_en = 0;
  logic area6_card_mode_bit = 0, standby_hiz_sel = 0, ras2_hiz_sel = 0, timer_clk_out_sel = 0;
  logic port_en = 0, sci_clk_out = 0, sci_clk_drive = 0, sci_tx_data = 0, dram_ras2_n = 1;
  logic timer_clk_src = 0, timer_clock_pin_i = 0, acc_valid = 0, acc_write = 0, acc_card = 0;
  logic acc_bus16 = 0, wait_req_n = 0, card16 = 0;
  logic [7:0] port_dir = 8'h00, port_out = 8'h00, port_pin_i = 8'h00;
  logic [1:0] port_top2_out = 2'h0, acc_size = 2'h0;
  logic [2:0] wait_setting_reg = 3'h0, acc_area = 3'h0;
  logic [5:0] strap_set = 6'h00;
  logic [15:0] acc_wdata = 16'h0000, data_i = 16'h0000, wd = 16'hA55A;
  logic [25:0] acc_addr = 26'h000_0000;
  logic [7:0] ck_m = `EBPC_CKIO_OUT_MASK, xt_m = `EBPC_XTAL_USE_MASK;
  wire chip_active_in, card_io_width_flag, bus_ack_n, hw_standby, strap2_serial_in_i;
  wire strap0_serial_clock_i, strap0_serial_clock_o, strap0_serial_clock_oe;
  wire strap1_serial_out_i, strap1_serial_out_o, strap1_serial_out_oe;
  wire width_strap_card_enable_a_i, width_strap_card_enable_a_o, width_strap_card_enable_a_oe;
  wire width_strap_card_enable_b_i, width_strap_card_enable_b_o, width_strap_card_enable_b_oe;
  wire endian_strap_row_strobe2_i, endian_strap_row_strobe2_o, endian_strap_row_strobe2_oe;
  wire big_endian_mode, ckio_oe, xtal_osc_en, sci_clk_in, sci_rx_data, timer_clk_in;
  wire timer_clock_pin_o, timer_clock_pin_oe, wait_active, card_io16, addr_oe, rd_oe;
  wire area_selects_oe, cycle_start_strobe_n, cycle_start_strobe_oe, rd_n, rd_wr;
  wire lane0_write_strobe_n, lane1_write_strobe_n, write_strobe_oe, data_top2_oe;
  wire [1:0] area0_width_mode, data_lane_oe, data_top2_o;
  wire [2:0] clock_mode_straps;
  wire [6:0] area_selects_n;
  wire [7:0] port_pin_o, port_pin_oe, port_in;
  wire [15:0] data_o, read_data;
  wire [25:0] addr_o;
  int err_count = 0, samples_checked = 0, i;
  // Fields: write, size, addr0, bus16, we0, we1, rd, rd/wr, lane enables
  logic [10:0] rows [7] = '{11'b0_00_0_1_1_1_0_1_00, 11'b1_00_0_1_0_1_1_0_01,
    11'b1_00_1_1_1_0_1_0_10, 11'b1_01_0_1_0_0_1_0_11, 11'b1_10_0_1_0_0_1_0_11,
    11'b1_00_1_0_0_1_1_0_01, 11'b0_01_0_1_1_1_0_1_00};
  ebpc_pin_ctrl dut (.*);
  ebpc_board u_board (.*);
  always #2 mclk = ~mclk;
  task complete_run;
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [25:0] seen, input logic [25:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task chk_row(input logic [10:0] r, input int a);
    logic [15:0] m, ex;
    logic [6:0] s;
    m = {{8{r[1]}}, {8{r[0]}}};
    ex = {r[1] ? (r[9:8] == 2'h0 ? wd[7:0] : wd[15:8]) : 8'h00, r[0] ? wd[7:0] : 8'h00};
    s = ~(7'h01 << a);
    chk(lane0_write_strobe_n, r[5]);
    chk(lane1_write_strobe_n, r[4]);
    chk(rd_n, r[3]);
    chk(rd_wr, r[2]);
    chk(data_lane_oe, r[1:0]);
    chk(data_o & m, ex);
    chk(area_selects_n, s);
    chk(wait_active, 1'b0);
  endtask
  // Bounded wait on bus acknowledge or hardware standby
  task wait_for(input bit hw, input logic lvl);
    int n;
    for (n = 0; n < 20 && (hw ? hw_standby : bus_ack_n) !== lvl; n++) begin
      @(posedge mclk);
      #1;
    end
    if ((hw ? hw_standby : bus_ack_n) !== lvl) begin
      err_count++;
      complete_run();
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  initial begin
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      strap_set <= {~i[2:0], i[2:0]};
      rst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      strap_set <= {i[2:0], ~i[2:0]};
      settle(2);
      chk(clock_mode_straps, i[2:0]);
      chk(area0_width_mode, {~i[1:0]});
      chk(big_endian_mode, {~i[2]});
      chk(ckio_oe, ck_m[i]);
      chk(xtal_osc_en, xt_m[i]);
    end
    // Back-to-back accesses, each row checked while the next is presented
    for (i = 0; i <= 7; i++) begin
      @(posedge mclk);
      if (i < 7) begin
        acc_valid <= 1'b1;
        {acc_write, acc_size} <= rows[i][10:8];
        acc_addr <= {25'h000_0100, rows[i][7]};
        acc_bus16 <= rows[i][6];
        acc_area <= i[2:0];
        acc_wdata <= wd;
      end else acc_valid <= 1'b0;
      #1;
      if (i > 0) chk_row(rows[i - 1], i - 1);
    end
    // Nonzero wait setting lets the wait request through
    {wait_setting_reg, acc_card, card16, acc_valid} <= 6'h0F;
    settle(1);
    acc_valid <= 1'b0;
    chk({wait_active, card_io16}, 2'h3);
    {serial_en, sci_clk_drive, sci_clk_out, sci_tx_data, area5_card_en} <= 5'h1F;
    {area6_card_mode_bit, area2_dram_en, dram_ras2_n, port_en, strap_set} <= 10'h37C;
    {port_dir, port_out, port_top2_out, data_i} <= {8'hF0, 8'hA5, 2'h2, 16'h1234};
    settle(3);
    chk(strap0_serial_clock_oe, 1'b1);
    chk(strap1_serial_out_o, 1'b1);
    chk(sci_rx_data, 1'b1);
    chk(endian_strap_row_strobe2_o, 1'b0);
    chk(width_strap_card_enable_b_oe, 1'b1);
    chk(width_strap_card_enable_a_oe, 1'b1);
    chk(port_pin_o & port_pin_oe, 8'hA0);
    chk({data_top2_oe, data_top2_o}, 3'h6);
    chk(read_data, 16'h1234);
    // A read offered in standby must be ignored
    {standby_hiz_sel, ras2_hiz_sel, standby_req, acc_valid, acc_write} <= 5'h1E;
    // Port data changes only once standby is reached, so keep must hold it
    settle(1);
    port_out <= 8'h5A;
    settle(2);
    chk({area_selects_oe, cycle_start_strobe_oe, write_strobe_oe}, 3'h0);
    chk(endian_strap_row_strobe2_oe, 1'b0);
    chk(port_pin_o & port_pin_oe, 8'hA0);
    chk(rd_n, 1'b1);
    standby_hiz_sel <= 1'b0;
    settle(2);
    chk({area_selects_oe, area_selects_n, lane0_write_strobe_n}, 9'h1FF);
    {standby_req, acc_valid, bus_grant_request_n} <= 3'h0;
    wait_for(0, 1'b0);
    chk({addr_oe, rd_oe, area_selects_oe}, 3'h0);
    chk(endian_strap_row_strobe2_oe, 1'b0);
    ras2_hiz_sel <= 1'b0;
    settle(2);
    chk(endian_strap_row_strobe2_oe, 1'b1);
    bus_grant_request_n <= 1'b1;
    wait_for(0, 1'b1);
    {timer_clk_out_sel, ca_drop} <= 2'h3;
    wait_for(1, 1'b1);
    settle(2);
    chk({timer_clock_pin_oe, timer_clock_pin_o}, 2'h2);
    timer_clk_out_sel <= 1'b0;
    settle(2);
    chk(timer_clock_pin_oe, 1'b0);
    complete_run();
  end
endmodule
